// ### rtl/eac_pkg.sv
// Purpose: shared constants and types of the data eeprom access control block
// Assumes: apb slave with 32-bit data, 10 MHz pclk, byte-wide data array of 256 cells
// Notes:   every offset, field position, reset value and timing count lives here

package eac_pkg;

   // ---------------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------------
   localparam logic [11:0] OFS_CONTROL = 12'h000;  // memory_control_reg
   localparam logic [11:0] OFS_UNLOCK  = 12'h004;  // unlock_key_port, write only
   localparam logic [11:0] OFS_ADDRESS = 12'h008;  // memory_address_reg
   localparam logic [11:0] OFS_DATA    = 12'h00c;  // memory_data_reg
   localparam logic [11:0] OFS_STATUS  = 12'h010;  // done flag, timer and busy status

   // ---------------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------------
   localparam int BIT_RD    = 0;  // read trigger
   localparam int BIT_WR    = 1;  // write trigger
   localparam int BIT_WRITE_ENABLE_BIT  = 2;  // write_enable_bit
   localparam int BIT_WRITE_ERROR_FLAG = 3;  // write_error_flag
   localparam int BIT_FREE  = 4;  // row erase enable
   localparam int BIT_CONFIG_SPACE_SELECT  = 6;  // config_space_select
   localparam int BIT_PSS   = 7;  // program_space_select
   localparam int BIT_DONE  = 0;  // write_done_flag in status
   localparam int BIT_PWRT  = 1;  // power-up timer running
   localparam int BIT_BUSY  = 2;  // self-timed write in progress

   // ---------------------------------------------------------------------
   // reset values and key values
   // ---------------------------------------------------------------------
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] ADDRESS_RST = 8'h00;
   localparam logic [7:0] DATA_RST    = 8'h00;
   localparam logic [7:0] KEY_FIRST   = 8'h55;
   localparam logic [7:0] KEY_SECOND  = 8'haa;

   // ---------------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------------
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned PWRT_MS      = 72;
   localparam int unsigned PWRT_CYCLES  = PWRT_MS * (CLK_HZ / 1000);
   localparam int unsigned WRITE_US     = 4000;
   localparam int unsigned WRITE_CYCLES = WRITE_US * (CLK_HZ / 1_000_000);
   localparam int          PWRT_W       = 20;
   localparam int          WRT_W        = 16;
   localparam int          ADDR_W       = 8;

   // ---------------------------------------------------------------------
   // unlock sequence tracker
   // ---------------------------------------------------------------------
   typedef enum logic [1:0] {
      UNL_IDLE  = 2'b00,
      UNL_FIRST = 2'b01,
      UNL_ARMED = 2'b10
   } eac_unlock_t;

endpackage

// ### rtl/eac_mem_if.sv
// Purpose: carrier between the control logic and the timed data array
// Assumes: one pclk domain
// Notes:   start is a one-cycle pulse, done a one-cycle pulse at write end

`timescale 1ns/1ps

interface eac_mem_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       start;
   logic [7:0] rdata;
   logic       busy;
   logic       done;

   modport ctrl  (output addr, output wdata, output start,
                  input  rdata, input busy, input done);
   modport array (input  addr, input wdata, input start,
                  output rdata, output busy, output done);
endinterface

// ### rtl/eac_array.sv
// Purpose: data eeprom cell array with a self-timed byte write
// Assumes: start only arrives while busy is low
// Notes:   cells are not reset, as a real nonvolatile array keeps its contents

`timescale 1ns/1ps

module eac_array
   import eac_pkg::*;
#(
   parameter int unsigned WRITE_LEN = WRITE_CYCLES
) (
   input wire logic  pclk,
   input wire logic  presetn,
   eac_mem_if.array  mem
);

   logic [7:0]       cells [256];
   logic             busy;
   logic             next_busy;
   logic [WRT_W-1:0] count;
   logic [WRT_W-1:0] next_count;
   logic [7:0]       wr_addr;
   logic [7:0]       next_wr_addr;
   logic [7:0]       wr_data;
   logic [7:0]       next_wr_data;
   logic             finish;

   // ---------------------------------------------------------------------
   // write timer
   // ---------------------------------------------------------------------
   // address and data are captured at start, so the cell written is the one asked for
   always_comb begin
      next_busy    = busy;
      next_count   = count;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      finish       = 1'b0;
      if (busy) begin
         if (count == '0) begin
            next_busy = 1'b0;
            finish    = 1'b1;
         end else begin
            next_count = count - 1'b1;
         end
      end else if (mem.start) begin
         next_busy    = 1'b1;
         next_count   = WRT_W'(WRITE_LEN - 1);
         next_wr_addr = mem.addr;
         next_wr_data = mem.wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy    <= 1'b0;
         count   <= '0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         busy    <= next_busy;
         count   <= next_count;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
      end
   end

   // cell update happens only at the very end of the timed cycle
   always_ff @(posedge pclk) begin
      if (finish) begin
         cells[wr_addr] <= wr_data;
      end
   end

   assign mem.rdata = cells[mem.addr];
   assign mem.busy  = busy;
   assign mem.done  = finish;

endmodule

// ### rtl/eac_ctrl.sv
// Purpose: apb register front end and access control of the data eeprom
// Assumes: zero-wait apb slave; only byte lane 0 of pwdata is used
// Notes:   write and power-up times are parameters so a bench can shorten them
//
// Register access over APB and the register offsets are this design's own decisions.

`timescale 1ns/1ps

// Contract
// (R01) read trigger runs one cycle, self-clears
// (R02) software can only set read trigger
// (R03) read trigger refused while program select set
// (R04) read byte lands in data next cycle
// (R05) data keeps read value until replaced
// (R06) keys 55h then AAh before write trigger
// (R07) write trigger needs write enable already set
// (R08) hardware never clears write enable
// (R09) control, address, data frozen during write; a read triggered in the same control write still loads data mid-write
// (R10) write end clears trigger, sets done flag
// (R11) software clears the done flag itself
// (R12) write enable cleared at power-up
// (R13) no writes while power-up timer runs
// (R14) software loads address and data first
// (R15) software keeps key writes back to back
// (R16) software keeps write enable mostly clear
// (R17) error leaves program select, erase untouched
// (R18) program select zero means data eeprom
// (R19) config select zero means memory arrays
// (R20) write trigger stays set whole write
// (R21) key port unreadable; other access resets tracker
module eac_ctrl
   import eac_pkg::*;
#(
   parameter int unsigned PWRT_LEN  = PWRT_CYCLES,
   parameter int unsigned WRITE_LEN = WRITE_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   // ---------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------
   logic              ctl_pss;
   logic              ctl_config_space_select;
   logic              ctl_free;
   logic              ctl_write_error_flag;
   logic              ctl_write_enable_bit;
   logic              ctl_wr;
   logic              ctl_rd;
   logic [7:0]        addr_reg;
   logic [7:0]        data_reg;
   logic              done_flag;
   eac_unlock_t       unl;
   logic [PWRT_W-1:0] pwrt_cnt;
   logic              pwrt_busy;
   logic [31:0]       rdata_q;
   logic              slverr_q;

   logic              next_pss;
   logic              next_config_space_select;
   logic              next_free;
   logic              next_write_error_flag;
   logic              next_write_enable_bit;
   logic              next_wr;
   logic              next_rd;
   logic [7:0]        next_addr;
   logic [7:0]        next_data;
   logic              next_done;
   eac_unlock_t       next_unl;
   logic [PWRT_W-1:0] next_pwrt_cnt;
   logic              next_pwrt_busy;
   logic [31:0]       next_rdata;
   logic              next_slverr;

   logic              acc;
   logic              wr_acc;
   logic              start_write;
   logic              start_ok;
   logic              rd_ok;
   logic [7:0]        wbyte;

   eac_mem_if mem_bus ();

   // ---------------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------------
   // address decode, used for the error answer only; the read mux decodes paddr itself
   function automatic logic eac_mapped(input logic [11:0] a);
      return (a == OFS_CONTROL) || (a == OFS_UNLOCK) || (a == OFS_ADDRESS) ||
             (a == OFS_DATA) || (a == OFS_STATUS);
   endfunction

   function automatic logic [7:0] eac_control_byte(input logic pss, input logic config_space_select,
                                                   input logic free, input logic write_error_flag,
                                                   input logic write_enable_bit, input logic wr,
                                                   input logic rd);
      logic [7:0] v;
      v            = 8'h00;  // bit 5 reads as zero
      v[BIT_PSS]   = pss;
      v[BIT_CONFIG_SPACE_SELECT]  = config_space_select;
      v[BIT_FREE]  = free;
      v[BIT_WRITE_ERROR_FLAG] = write_error_flag;
      v[BIT_WRITE_ENABLE_BIT]  = write_enable_bit;
      v[BIT_WR]    = wr;
      v[BIT_RD]    = rd;
      return v;
   endfunction

   // ---------------------------------------------------------------------
   // apb handshake
   // ---------------------------------------------------------------------
   // zero wait states: every access phase completes at its first edge
   assign pready  = 1'b1;
   assign pslverr = slverr_q & psel & penable;
   assign prdata  = rdata_q;
   assign acc     = psel & penable;
   assign wr_acc  = acc & pwrite & pstrb[0];
   assign wbyte   = pwdata[7:0];

   // only the data eeprom is behind this block, so both selects must be zero
   assign rd_ok    = ~ctl_pss & ~ctl_config_space_select;  // (R03) (R18) (R19)
   // stored write enable is used, so setting it in the same write does not count
   assign start_ok = ctl_write_enable_bit & (unl == UNL_ARMED) & ~pwrt_busy & ~ctl_pss & ~ctl_config_space_select
                     & ~ctl_wr & ~mem_bus.busy;  // (R06) (R07) (R13)

   // ---------------------------------------------------------------------
   // register next values
   // ---------------------------------------------------------------------
   always_comb begin
      next_pss       = ctl_pss;
      next_config_space_select      = ctl_config_space_select;
      next_free      = ctl_free;
      next_write_error_flag     = ctl_write_error_flag;
      next_write_enable_bit      = ctl_write_enable_bit;
      next_wr        = ctl_wr;
      next_rd        = ctl_rd;
      next_addr      = addr_reg;
      next_data      = data_reg;
      next_done      = done_flag;
      start_write    = 1'b0;

      // a pending read finishes in the cycle after it was set
      if (ctl_rd) begin
         next_rd   = 1'b0;  // (R01)
         next_data = mem_bus.rdata;  // (R04) (R05)
      end

      // register writes; the frozen set is ignored while a write is timed
      if (wr_acc && !ctl_wr) begin
         unique case (paddr)
            OFS_CONTROL: begin
               next_pss   = wbyte[BIT_PSS];
               next_config_space_select  = wbyte[BIT_CONFIG_SPACE_SELECT];
               next_free  = wbyte[BIT_FREE];
               next_write_error_flag = wbyte[BIT_WRITE_ERROR_FLAG];
               next_write_enable_bit  = wbyte[BIT_WRITE_ENABLE_BIT];
               if (wbyte[BIT_RD] && rd_ok) begin
                  next_rd = 1'b1;  // (R02) (R03)
               end
               if (wbyte[BIT_WR] && start_ok) begin
                  next_wr     = 1'b1;  // (R06) (R07)
                  start_write = 1'b1;
               end
            end
            OFS_ADDRESS: next_addr = wbyte;
            OFS_DATA:    next_data = wbyte;  // (R05)
            default: ;
         endcase
      end else if (wr_acc && ctl_wr && paddr != OFS_STATUS) begin
         next_wr = ctl_wr;  // (R09)
      end

      // done flag: writing zero clears it, hardware set wins in the same cycle
      if (wr_acc && paddr == OFS_STATUS && !wbyte[BIT_DONE]) begin
         next_done = 1'b0;  // (R11)
      end
      // trigger held for the whole timed write, dropped only at its end;
      // write enable, program select and erase enable are left as they are
      if (mem_bus.done) begin
         next_wr   = 1'b0;  // (R10) (R20) (R08) (R17)
         next_done = 1'b1;  // (R10)
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_pss   <= CONTROL_RST[BIT_PSS];
         ctl_config_space_select  <= CONTROL_RST[BIT_CONFIG_SPACE_SELECT];
         ctl_free  <= CONTROL_RST[BIT_FREE];
         ctl_write_error_flag <= CONTROL_RST[BIT_WRITE_ERROR_FLAG];
         ctl_write_enable_bit  <= CONTROL_RST[BIT_WRITE_ENABLE_BIT];  // (R12)
         ctl_wr    <= CONTROL_RST[BIT_WR];
         ctl_rd    <= CONTROL_RST[BIT_RD];
         addr_reg  <= ADDRESS_RST;
         data_reg  <= DATA_RST;
         done_flag <= 1'b0;
      end else begin
         ctl_pss   <= next_pss;
         ctl_config_space_select  <= next_config_space_select;
         ctl_free  <= next_free;
         ctl_write_error_flag <= next_write_error_flag;
         ctl_write_enable_bit  <= next_write_enable_bit;
         ctl_wr    <= next_wr;
         ctl_rd    <= next_rd;
         addr_reg  <= next_addr;
         data_reg  <= next_data;
         done_flag <= next_done;
      end
   end

   // ---------------------------------------------------------------------
   // unlock tracker
   // ---------------------------------------------------------------------
   // any completed access other than the next expected key drops the sequence,
   // including the control write that consumes the armed state
   always_comb begin
      next_unl = unl;
      if (acc) begin
         if (pwrite && pstrb[0] && paddr == OFS_UNLOCK) begin
            unique case (unl)
               UNL_IDLE:  next_unl = (wbyte == KEY_FIRST) ? UNL_FIRST : UNL_IDLE;
               UNL_FIRST: next_unl = (wbyte == KEY_SECOND) ? UNL_ARMED :
                                     (wbyte == KEY_FIRST) ? UNL_FIRST : UNL_IDLE;
               UNL_ARMED: next_unl = (wbyte == KEY_FIRST) ? UNL_FIRST : UNL_IDLE;
               default:   next_unl = UNL_IDLE;
            endcase  // (R06) (R21)
         end else begin
            next_unl = UNL_IDLE;  // (R21)
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unl <= UNL_IDLE;
      end else begin
         unl <= next_unl;
      end
   end

   // ---------------------------------------------------------------------
   // power-up timer
   // ---------------------------------------------------------------------
   // counts once after reset release; writes stay blocked until it expires
   always_comb begin
      next_pwrt_cnt  = pwrt_cnt;
      next_pwrt_busy = pwrt_busy;
      if (pwrt_busy) begin
         if (pwrt_cnt == '0) begin
            next_pwrt_busy = 1'b0;  // (R13)
         end else begin
            next_pwrt_cnt = pwrt_cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwrt_cnt  <= PWRT_W'(PWRT_LEN - 1);
         pwrt_busy <= 1'b1;
      end else begin
         pwrt_cnt  <= next_pwrt_cnt;
         pwrt_busy <= next_pwrt_busy;
      end
   end

   // ---------------------------------------------------------------------
   // read data path
   // ---------------------------------------------------------------------
   // captured in the setup phase so prdata comes straight from a flop; the
   // values the registers take at this edge are shown (the power-up timer bit aside), so a read issued right
   // after a read trigger already sees the fresh byte
   always_comb begin
      next_rdata  = rdata_q;
      next_slverr = slverr_q;
      if (psel && !penable) begin
         next_slverr = ~eac_mapped(paddr);
         next_rdata  = 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               OFS_CONTROL: next_rdata[7:0] = eac_control_byte(next_pss, next_config_space_select, next_free,
                                                               next_write_error_flag, next_write_enable_bit, next_wr,
                                                               next_rd);
               OFS_ADDRESS: next_rdata[7:0] = addr_reg;
               OFS_DATA:    next_rdata[7:0] = next_data;  // (R04)
               OFS_STATUS: begin
                  next_rdata[BIT_DONE] = next_done;
                  next_rdata[BIT_PWRT] = pwrt_busy;
                  next_rdata[BIT_BUSY] = next_wr;
               end
               default: next_rdata = 32'h0000_0000;  // key port and holes read zero (R21)
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q  <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else begin
         rdata_q  <= next_rdata;
         slverr_q <= next_slverr;
      end
   end

   // ---------------------------------------------------------------------
   // array
   // ---------------------------------------------------------------------
   // address and data registers feed the array; frozen during a write unless a read was triggered along with it
   assign mem_bus.addr  = addr_reg;
   assign mem_bus.wdata = data_reg;
   assign mem_bus.start = start_write;

   eac_array #(
      .WRITE_LEN (WRITE_LEN)
   ) u_array (
      .pclk    (pclk),
      .presetn (presetn),
      .mem     (mem_bus.array)
   );

endmodule

// ### bench/eac_ctrl_chk.sv
// Purpose: port-level assertions for the eeprom access control block
// Assumes: zero-wait apb slave, one pclk domain
// Notes:   register state is internal, so only bus-visible relations are watched

`timescale 1ns/1ps

module eac_ctrl_chk
   import eac_pkg::*;
#(
   parameter int unsigned PWRT_LEN  = PWRT_CYCLES,
   parameter int unsigned WRITE_LEN = WRITE_CYCLES
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   logic acc;
   logic mapped;
   int   cnt;

   // access phase and address decode
   assign acc    = psel && penable;
   assign mapped = paddr inside {OFS_CONTROL, OFS_UNLOCK, OFS_ADDRESS, OFS_DATA, OFS_STATUS};

   // edges since reset release, saturating so it never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
      end else if (cnt < 1_000_000) begin
         cnt <= cnt + 1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   zero_wait_a: assert property (psel |-> pready)
      else $error("pready low while selected");
   rd_selfclear_a: assert property (acc && !pwrite && paddr == OFS_CONTROL
                                    |-> !prdata[BIT_RD])
      else $error("read trigger seen set");
   key_unread_a: assert property (acc && !pwrite && paddr == OFS_UNLOCK |-> prdata == 32'h0)
      else $error("key port read not zero");
   err_unmapped_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not flagged");
   mapped_ok_a: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access flagged");
   err_phase_a: assert property (pslverr |-> acc)
      else $error("pslverr outside access phase");
   rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data changed outside setup");
   timer_run_a: assert property (acc && !pwrite && paddr == OFS_STATUS
                                 && cnt + 4 < PWRT_LEN |-> prdata[BIT_PWRT])
      else $error("power-up timer ended early");
   timer_end_a: assert property (acc && !pwrite && paddr == OFS_STATUS
                                 && cnt > PWRT_LEN + 4 |-> !prdata[BIT_PWRT])
      else $error("power-up timer ended late");
endmodule

bind eac_ctrl eac_ctrl_chk #(.PWRT_LEN(PWRT_LEN), .WRITE_LEN(WRITE_LEN)) eac_ctrl_chk_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// ### bench/testbench.sv
// Purpose: directed register-level test of the eeprom access control block
// Assumes: apb master in this bench, short timer and write counts
// Notes:   every transfer is followed by one idle cycle for simplicity

`timescale 1ns/1ps

module testbench
   import eac_pkg::*;
;
   localparam int unsigned PW = 40;  // short power-up time
   localparam int unsigned WL = 30;  // short write, long enough to poke during it
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rd;
   logic        err;
   int          err_count;
   int          checks_done;
   logic [7:0]  k1 [4] = '{8'haa, 8'h55, 8'h55, 8'h55};
   logic [7:0]  k2 [4] = '{8'h55, 8'h55, 8'haa, 8'haa};
   logic [7:0]  sel [2] = '{8'h80, 8'h40};

   eac_ctrl #(.PWRT_LEN(PW), .WRITE_LEN(WL)) eac_ctrl_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   always #50 pclk = ~pclk;

   // --------------------------------------------------------------
   // bus tasks and compares
   // --------------------------------------------------------------
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no wait count is assumed; a stuck slave is left to the watchdog
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic chk_byte(input string nm, input logic [7:0] e);
      checks_done++;
      if (rd !== {24'h0, e}) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, rd);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   // polls a bit, bounded so a stuck bit fails instead of hanging
   task automatic wait_bit(input logic [11:0] a, input int b, input logic v);
      for (int i = 0; i < 60; i++) begin
         xfer(1'b0, a, 8'h00);
         if (rd[b] === v) break;
      end
      chk_bit("poll", v, rd[b]);
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // --------------------------------------------------------------
   // test sequence
   // --------------------------------------------------------------
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; pstrb = 4'hf; err_count = 0; checks_done = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      xfer(0, OFS_STATUS, 0); chk_bit("timer", 1'b1, rd[BIT_PWRT]);
      xfer(0, OFS_CONTROL, 0); chk_byte("control reset", CONTROL_RST);
      // full unlock while the timer runs must not start a write
      xfer(1, OFS_ADDRESS, 8'h5a); xfer(1, OFS_DATA, 8'hc3); xfer(1, OFS_CONTROL, 8'h04);
      xfer(1, OFS_UNLOCK, 8'h55); xfer(1, OFS_UNLOCK, 8'haa); xfer(1, OFS_CONTROL, 8'h06);
      xfer(0, OFS_CONTROL, 0); chk_byte("early write", 8'h04);
      wait_bit(OFS_STATUS, BIT_PWRT, 1'b0);
      // broken key orders and interposed accesses
      for (int i = 0; i < 4; i++) begin
         xfer(1, OFS_UNLOCK, k1[i]);
         if (i == 2) xfer(0, OFS_DATA, 0);
         xfer(1, OFS_UNLOCK, k2[i]);
         if (i == 3) xfer(0, OFS_DATA, 0);
         xfer(1, OFS_CONTROL, 8'h06);
         xfer(0, OFS_CONTROL, 0); chk_byte("bad unlock", 8'h04);
      end
      xfer(1, OFS_CONTROL, 8'h00); xfer(1, OFS_UNLOCK, 8'h55); xfer(1, OFS_UNLOCK, 8'haa);
      xfer(1, OFS_CONTROL, 8'h06); xfer(0, OFS_CONTROL, 0); chk_byte("same write_enable_bit", 8'h04);
      pstrb <= 4'h0;
      xfer(1, OFS_ADDRESS, 8'h11);
      pstrb <= 4'hf;
      xfer(0, OFS_ADDRESS, 0); chk_byte("no strobe", 8'h5a);
      // proper write, then attempts to disturb it
      xfer(1, OFS_UNLOCK, 8'h55); xfer(1, OFS_UNLOCK, 8'haa); xfer(1, OFS_CONTROL, 8'h06);
      xfer(0, OFS_CONTROL, 0); chk_byte("write busy", 8'h06);
      xfer(1, OFS_ADDRESS, 8'h11); xfer(1, OFS_DATA, 8'h22); xfer(1, OFS_CONTROL, 8'h00);
      xfer(0, OFS_STATUS, 0); chk_bit("busy", 1'b1, rd[BIT_BUSY]);
      wait_bit(OFS_CONTROL, BIT_WR, 1'b0);
      chk_byte("write_enable_bit kept", 8'h04);
      xfer(0, OFS_STATUS, 0); chk_bit("done", 1'b1, rd[BIT_DONE]);
      xfer(0, OFS_ADDRESS, 0); chk_byte("addr frozen", 8'h5a);
      xfer(0, OFS_DATA, 0); chk_byte("data frozen", 8'hc3);
      xfer(1, OFS_STATUS, 8'h01); xfer(0, OFS_STATUS, 0);
      chk_bit("done kept", 1'b1, rd[BIT_DONE]);
      xfer(1, OFS_STATUS, 8'h00); xfer(0, OFS_STATUS, 0);
      chk_bit("done clr", 1'b0, rd[BIT_DONE]);
      // read back the written cell
      xfer(1, OFS_DATA, 8'h00); xfer(1, OFS_CONTROL, 8'h05);
      xfer(0, OFS_DATA, 0); chk_byte("read data", 8'hc3);
      xfer(0, OFS_CONTROL, 0); chk_byte("rd cleared", 8'h04);
      xfer(0, OFS_DATA, 0); chk_byte("data held", 8'hc3);
      xfer(1, OFS_DATA, 8'h77); xfer(0, OFS_DATA, 0); chk_byte("data write", 8'h77);
      // selects other than the data array refuse reads and writes
      for (int i = 0; i < 2; i++) begin
         xfer(1, OFS_CONTROL, sel[i] | 8'h04); xfer(1, OFS_CONTROL, sel[i] | 8'h05);
         xfer(0, OFS_CONTROL, 0); chk_byte("sel read", sel[i] | 8'h04);
         xfer(0, OFS_DATA, 0); chk_byte("sel data", 8'h77);
         xfer(1, OFS_UNLOCK, 8'h55); xfer(1, OFS_UNLOCK, 8'haa);
         xfer(1, OFS_CONTROL, sel[i] | 8'h06);
         xfer(0, OFS_CONTROL, 0); chk_byte("sel write", sel[i] | 8'h04);
      end
      xfer(1, OFS_CONTROL, 8'h9c); xfer(0, OFS_CONTROL, 0); chk_byte("error bits", 8'h9c);
      xfer(0, OFS_UNLOCK, 0); chk_byte("key read", 8'h00);
      xfer(0, 12'h014, 0); chk_bit("slverr", 1'b1, err);
      chk_byte("unmapped", 8'h00);
      // second reset in mid-run: write enable and the power-up timer start over
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      xfer(0, OFS_CONTROL, 0);
      chk_byte("control rearm", CONTROL_RST);
      xfer(0, OFS_STATUS, 0);
      chk_bit("timer rearm", 1'b1, rd[BIT_PWRT]);
      final_report();
   end

   // watchdog, generous against roughly three hundred expected cycles
   initial begin
      repeat (4000) @(posedge pclk);
      err_count++;
      final_report();
   end
endmodule
